// ### src/ep_cfg_pkg.sv
package ep_cfg_pkg;

    // ------------------------------------------------------------
    // Bus and map
    // ------------------------------------------------------------
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    localparam int         EP_W          = 4;
    localparam int         EP_COUNT      = 16;
    localparam logic [7:0] OFF_INDEX     = 8'h00;
    localparam logic [7:0] OFF_PKT_SIZE  = 8'h04;
    localparam logic [7:0] OFF_KIND_CTL  = 8'h08;
    localparam logic [7:0] OFF_BUF_LEN   = 8'h1c;
    localparam logic [7:0] OFF_EP_STATUS = 8'h0c;
    localparam logic [7:0] OFF_CONTROL   = 8'h10;
    localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int          FIFO_SIZE_LSB  = 0;
    localparam int          FIFO_SIZE_W    = 11;
    localparam int          TRANS_LSB      = 11;
    localparam int          KIND_LSB       = 0;
    localparam int          DBL_BIT        = 2;
    localparam int          ENABLE_BIT     = 3;
    localparam int          NOZLP_BIT      = 4;
    localparam logic [15:0] PKT_SIZE_MASK  = 16'h1fff;
    localparam logic [15:0] KIND_CTL_MASK  = 16'h001f;
    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam int          CTL_BUS_RESET  = 0;
    localparam int          STS_TOGGLE     = 0;
    localparam int          STS_ENABLE     = 1;

    typedef enum logic [1:0] {
        KIND_UNUSED, KIND_ISO, KIND_BULK, KIND_INTR
    } transfer_kind_e;

    // Per-endpoint configuration as seen by the endpoint engine
    typedef struct packed {
        logic [1:0]  transactions_per_microframe;
        logic [10:0] fifo_byte_size;
        logic        suppress_zero_length_packet;
        logic        enable;
        logic        double_buffer_on;
        logic [1:0]  transfer_kind;
    } ep_cfg_s;

endpackage

// ### src/ep_cfg_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ep_cfg_mem
    import ep_cfg_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_rst_n,
    input  wire logic            i_clear,
    input  wire logic            i_we,
    input  wire logic [EP_W-1:0] i_waddr,
    input  wire logic [15:0]     i_wdata,
    input  wire logic [EP_W-1:0] i_raddr,
    output logic      [15:0]     o_rdata
);

    logic [15:0] mem_q [EP_COUNT];

    // ------------------------------------------------------------
    // Storage cleared on device and bus reset
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < EP_COUNT; g++) begin : g_ent
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    mem_q[g] <= REG_RESET;
                end else if (i_clear) begin
                    mem_q[g] <= REG_RESET;
                end else if (i_we && i_waddr == EP_W'(g)) begin
                    mem_q[g] <= i_wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= REG_RESET;
        end else begin
            o_rdata <= mem_q[i_raddr];
        end
    end

endmodule
`default_nettype wire

// ### src/usb_endpoint_config_regs.sv
// Function
// RULE1: Writing packet-size register reloads indexed buffer-length count with new FIFO size.
// RULE2: Packet-size register governs data endpoints only; control endpoint zero is excluded.
// RULE3: Bits 12:11 give transactions per microframe, for isochronous and interrupt only.
// RULE4: Bits 10:0 give FIFO size in bytes, for both speeds.
// RULE5: Software keeps enabled FIFO sizes summed within 4096 bytes.
// RULE6: Software writes reserved bits as zero.
// RULE7: Bit 4 clear sends zero-length packet after DMA IN completes; set suppresses it.
// RULE8: Bit 3 enables the indexed endpoint FIFO; clear disables it.
// RULE9: Disable then enable of an endpoint resets its data toggle.
// RULE10: Bit 2 enables double buffering; clear leaves single buffering.
// RULE11: Bits 1:0 select transfer kind: unused, isochronous, bulk, interrupt.
// RULE12: Software selects endpoint index first; accesses apply to that endpoint.
// RULE13: USB bus reset clears the buffer-length count to zero.
// RULE14: Both config registers clear on device reset and USB bus reset.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_config_regs
    import ep_cfg_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic      [DATA_W-1:0] o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic              i_usb_bus_reset,
    input  wire logic [EP_W-1:0]   i_eng_ep,
    input  wire logic              i_eng_dma_in_done,
    input  wire logic              i_eng_toggle_flip,
    output ep_cfg_s                o_eng_cfg,
    output logic                   o_eng_send_zlp,
    output logic                   o_eng_toggle,
    output logic [EP_COUNT-1:0]    o_ep_enable,
    output logic [15:0]            o_buffer_length_count
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DONE} bus_st_e;

    bus_st_e         st_q;
    logic [EP_W-1:0] index_q;
    logic [15:0]     blen_q [EP_COUNT];
    logic [15:0]     kind_q [EP_COUNT];
    logic            tog_q [EP_COUNT];
    logic            bus_rst_q;

    wire        req       = (i_avs_read | i_avs_write) && st_q == ST_IDLE;
    wire        lo_en     = i_avs_byteenable[0] | i_avs_byteenable[1];
    wire [15:0] wmask     = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    wire        hit_index = i_avs_address == OFF_INDEX;
    wire        hit_pkt   = i_avs_address == OFF_PKT_SIZE;
    wire        hit_kind  = i_avs_address == OFF_KIND_CTL;
    wire        hit_blen  = i_avs_address == OFF_BUF_LEN;
    wire        hit_sts   = i_avs_address == OFF_EP_STATUS;
    wire        hit_ctl   = i_avs_address == OFF_CONTROL;
    // Commit at the acknowledge edge
    wire        wr_go     = i_avs_write && st_q == ST_DONE && lo_en;
    wire        data_ep   = index_q != '0; // RULE2
    wire        wr_pkt    = wr_go && hit_pkt && data_ep; // RULE12
    wire        wr_kind   = wr_go && hit_kind && data_ep;
    wire        wr_blen   = wr_go && hit_blen && data_ep;
    wire        wr_ctl    = wr_go && hit_ctl;
    wire        bus_reset = i_usb_bus_reset | bus_rst_q;

    // ------------------------------------------------------------
    // Packet-size storage
    // ------------------------------------------------------------
    logic [15:0] pkt_rd;
    logic [15:0] pkt_old;
    logic [15:0] pkt_new;

    assign pkt_old = pkt_rd;
    assign pkt_new = (i_avs_writedata[15:0] & wmask & PKT_SIZE_MASK)
                   | (pkt_old & ~wmask); // RULE3 RULE4

    ep_cfg_mem u_pkt_mem (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_clear (bus_reset), // RULE14
        .i_we    (wr_pkt),
        .i_waddr (index_q),
        .i_wdata (pkt_new),
        .i_raddr (st_q == ST_IDLE ? index_q : i_eng_ep),
        .o_rdata (pkt_rd)
    );

    // ------------------------------------------------------------
    // Index, control and bus state
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            index_q   <= '0;
            bus_rst_q <= 1'b0;
        end else begin
            if (wr_go && hit_index) begin
                index_q <= i_avs_writedata[EP_W-1:0];
            end
            if (wr_ctl) begin
                bus_rst_q <= i_avs_writedata[CTL_BUS_RESET];
            end else begin
                bus_rst_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: st_q <= i_avs_read ? ST_READ : (i_avs_write ? ST_DONE : ST_IDLE);
                ST_READ: st_q <= ST_DONE;
                ST_DONE: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-endpoint kind control, length count and toggle
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < EP_COUNT; g++) begin : g_ep
            wire        sel      = index_q == EP_W'(g);
            wire [15:0] kind_new = (i_avs_writedata[15:0] & wmask & KIND_CTL_MASK)
                                 | (kind_q[g] & ~wmask);
            wire        reenable = sel && wr_kind && !kind_q[g][ENABLE_BIT]
                                 && kind_new[ENABLE_BIT];

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    kind_q[g] <= REG_RESET;
                end else if (bus_reset) begin
                    kind_q[g] <= REG_RESET; // RULE14
                end else if (sel && wr_kind) begin
                    kind_q[g] <= kind_new; // RULE7 RULE8 RULE10 RULE11
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    blen_q[g] <= REG_RESET;
                end else if (bus_reset) begin
                    blen_q[g] <= REG_RESET; // RULE13
                end else if (sel && wr_pkt) begin
                    blen_q[g] <= {5'h00, pkt_new[FIFO_SIZE_LSB +: FIFO_SIZE_W]}; // RULE1
                end else if (sel && wr_blen) begin
                    blen_q[g] <= (i_avs_writedata[15:0] & wmask) | (blen_q[g] & ~wmask);
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    tog_q[g] <= 1'b0;
                end else if (bus_reset || reenable) begin
                    tog_q[g] <= 1'b0; // RULE9
                end else if (i_eng_toggle_flip && i_eng_ep == EP_W'(g)
                             && kind_q[g][ENABLE_BIT]) begin
                    tog_q[g] <= ~tog_q[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path and engine outputs
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] raddr_q;
    wire  [15:0]       sts_word = {14'h0000, kind_q[index_q][ENABLE_BIT], tog_q[index_q]};
    wire  [15:0]       rd_word  =
        (raddr_q == OFF_INDEX)     ? {12'h000, index_q} :
        (raddr_q == OFF_PKT_SIZE)  ? (data_ep ? pkt_rd : REG_RESET) :
        (raddr_q == OFF_KIND_CTL)  ? kind_q[index_q] :
        (raddr_q == OFF_BUF_LEN)   ? blen_q[index_q] :
        (raddr_q == OFF_EP_STATUS) ? sts_word : UNMAPPED_RD[15:0];
    wire [15:0] eng_kind = kind_q[i_eng_ep];
    wire        eng_data = i_eng_ep != '0; // RULE2
    wire [15:0] eng_pkt  = eng_data ? pkt_rd : REG_RESET;
    wire        eng_per  = eng_kind[1:0] == KIND_ISO || eng_kind[1:0] == KIND_INTR;
    logic [EP_COUNT-1:0] en_vec;

    always_comb begin
        for (int i = 0; i < EP_COUNT; i++) begin
            en_vec[i] = kind_q[i][ENABLE_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            raddr_q <= '0;
        end else if (req) begin
            raddr_q <= i_avs_address;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata    <= '0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !(st_q == ST_READ || (st_q == ST_IDLE && i_avs_write));
            if (st_q == ST_READ) begin
                o_avs_readdata <= {16'h0000, rd_word};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_eng_cfg             <= '0;
            o_eng_send_zlp        <= 1'b0;
            o_eng_toggle          <= 1'b0;
            o_ep_enable           <= '0;
            o_buffer_length_count <= '0;
        end else begin
            o_eng_cfg.transactions_per_microframe <= eng_per ? eng_pkt[TRANS_LSB +: 2] : 2'b00; // RULE3
            o_eng_cfg.fifo_byte_size              <= eng_pkt[FIFO_SIZE_LSB +: FIFO_SIZE_W]; // RULE4
            o_eng_cfg.suppress_zero_length_packet <= eng_kind[NOZLP_BIT];
            o_eng_cfg.enable                      <= eng_kind[ENABLE_BIT] && eng_data; // RULE8
            o_eng_cfg.double_buffer_on            <= eng_kind[DBL_BIT]; // RULE10
            o_eng_cfg.transfer_kind               <= eng_kind[KIND_LSB +: 2]; // RULE11
            o_eng_send_zlp        <= i_eng_dma_in_done && !eng_kind[NOZLP_BIT]
                                     && eng_kind[ENABLE_BIT]; // RULE7
            o_eng_toggle          <= tog_q[i_eng_ep];
            o_ep_enable           <= en_vec;
            o_buffer_length_count <= blen_q[i_eng_ep];
        end
    end

endmodule
`default_nettype wire

// ### tb/usb_endpoint_config_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_config_regs_chk
    import ep_cfg_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic [DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0]        i_avs_byteenable,
    input wire logic [DATA_W-1:0] o_avs_readdata,
    input wire logic              o_avs_waitrequest,
    input wire logic              i_usb_bus_reset,
    input wire logic [EP_W-1:0]   i_eng_ep,
    input wire logic              i_eng_dma_in_done,
    input wire logic              i_eng_toggle_flip,
    input wire ep_cfg_s           o_eng_cfg,
    input wire logic              o_eng_send_zlp,
    input wire logic              o_eng_toggle,
    input wire logic [EP_COUNT-1:0] o_ep_enable,
    input wire logic [15:0]       o_buffer_length_count
);
    // ------------------------------------------------------------
    // Bus and engine relations
    // ------------------------------------------------------------
    wire logic acked = !o_avs_waitrequest;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_ack_single: assert property (acked |=> !acked)
        else $error("ack held too long");
    a_bus_answer: assert property ((i_avs_read || i_avs_write) |-> ##[0:3] acked)
        else $error("bus request not answered");
    a_zlp_cause: assert property (o_eng_send_zlp |-> $past(i_eng_dma_in_done))
        else $error("zero-length packet without dma done");
    a_zlp_enabled: assert property (o_eng_send_zlp |-> o_ep_enable[$past(i_eng_ep)])
        else $error("zero-length packet on disabled endpoint");
    a_trans_kind: assert property (o_eng_cfg.transactions_per_microframe != 2'b00
        |-> o_eng_cfg.transfer_kind[0]) else $error("transactions on bulk or unused");
    a_ep0_off: assert property (o_ep_enable[0] == 1'b0)
        else $error("control endpoint enabled");
    a_reset_cfg: assert property (i_usb_bus_reset [*3] |-> o_ep_enable == '0)
        else $error("enables kept over bus reset");
    a_reset_count: assert property (i_usb_bus_reset [*3] |-> o_buffer_length_count == 16'h0000)
        else $error("count kept over bus reset");
    a_enable_cause: assert property (o_ep_enable != $past(o_ep_enable)
        |-> $past(i_avs_write) || $past(i_avs_write, 2) || $past(i_avs_write, 3)
        || $past(i_usb_bus_reset)
        || $past(i_usb_bus_reset, 2)) else $error("enable changed without cause");
endmodule

bind usb_endpoint_config_regs usb_endpoint_config_regs_chk i_chk (.*);
`default_nettype wire

// ### tb/usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
    import ep_cfg_pkg::*;
(
    input  wire logic            i_clk,
    output logic      [EP_W-1:0] o_ep,
    output logic                 o_dma_in_done,
    output logic                 o_toggle_flip
);
    initial begin
        o_ep = '0;
        o_dma_in_done = 1'b0;
        o_toggle_flip = 1'b0;
    end
    task automatic aim(input logic [EP_W-1:0] e);
        @(posedge i_clk);
        o_ep <= e;
    endtask
    // One-cycle engine event, outputs settled on return
    task automatic pulse(input logic flip_not_done);
        @(posedge i_clk);
        if (flip_not_done) o_toggle_flip <= 1'b1;
        else o_dma_in_done <= 1'b1;
        @(posedge i_clk);
        o_toggle_flip <= 1'b0;
        o_dma_in_done <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_usb_endpoint_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_config_regs
    import ep_cfg_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, bus_rst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  be = 4'h3;
    logic [15:0] ens, blen;
    logic [EP_W-1:0] ep;
    logic        dma_done, flip, wait_r, zlp, tog;
    ep_cfg_s     cfg;
    int          fails = 0, tests_run = 0;

    usb_endpoint_config_regs i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .i_usb_bus_reset(bus_rst),
        .i_eng_ep(ep), .i_eng_dma_in_done(dma_done), .i_eng_toggle_flip(flip),
        .o_eng_cfg(cfg), .o_eng_send_zlp(zlp), .o_eng_toggle(tog), .o_ep_enable(ens),
        .o_buffer_length_count(blen));
    usb_host_model i_host (.i_clk(clk), .o_ep(ep), .o_dma_in_done(dma_done),
        .o_toggle_flip(flip));

    initial forever #5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        if (fails == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {16'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            fails++;
            results();
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0, q);
        chk(q, {16'h0, e});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset();
        wreg(OFF_INDEX, 16'h0003);
        rchk(OFF_PKT_SIZE, 16'h0000);
        rchk(OFF_KIND_CTL, 16'h0000);
        rchk(8'h40, 16'h0000);
    endtask
    task automatic sc_size();
        wreg(OFF_INDEX, 16'h0005);
        wreg(OFF_PKT_SIZE, 16'h1040);
        rchk(OFF_PKT_SIZE, 16'h1040);
        rchk(OFF_BUF_LEN, 16'h0040);
        wreg(OFF_BUF_LEN, 16'h0012);
        be <= 4'h1;
        wreg(OFF_PKT_SIZE, 16'h00aa);
        be <= 4'h3;
        rchk(OFF_PKT_SIZE, 16'h10aa);
        rchk(OFF_BUF_LEN, 16'h00aa);
        wreg(OFF_PKT_SIZE, 16'h17ff);
        rchk(OFF_BUF_LEN, 16'h07ff);
        rchk(OFF_PKT_SIZE, 16'h17ff);
        wreg(OFF_INDEX, 16'h0000);
        wreg(OFF_PKT_SIZE, 16'h0200);
        rchk(OFF_PKT_SIZE, 16'h0000);
        wreg(OFF_INDEX, 16'h0006);
        rchk(OFF_PKT_SIZE, 16'h0000);
        wreg(OFF_INDEX, 16'h0005);
    endtask
    task automatic sc_kinds();
        logic [1:0] k;
        i_host.aim(4'h5);
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            wreg(OFF_KIND_CTL, {11'h0, 1'b0, 1'b1, k[0], k});
            repeat (4) @(posedge clk);
            chk({14'h0, cfg}, {14'h0, k[0] ? 2'b10 : 2'b00, 11'h7ff, 2'b01, k[0], k});
        end
        chk({16'h0, blen}, 32'h0000_07ff);
    endtask
    task automatic sc_zlp();
        i_host.pulse(1'b0);
        chk({31'h0, zlp}, 32'h1);
        wreg(OFF_KIND_CTL, 16'h001f);
        repeat (4) @(posedge clk);
        i_host.pulse(1'b0);
        chk({31'h0, zlp}, 32'h0);
    endtask
    task automatic sc_toggle();
        i_host.pulse(1'b1);
        repeat (3) @(posedge clk);
        chk({31'h0, tog}, 32'h1);
        wreg(OFF_KIND_CTL, 16'h0003);
        repeat (3) @(posedge clk);
        chk({31'h0, ens[5]}, 32'h0);
        wreg(OFF_KIND_CTL, 16'h000b);
        repeat (3) @(posedge clk);
        chk({31'h0, tog}, 32'h0);
        chk({31'h0, ens[5]}, 32'h1);
        rchk(OFF_EP_STATUS, 16'h0002);
    endtask
    task automatic sc_bus_reset();
        @(posedge clk);
        bus_rst <= 1'b1;
        repeat (3) @(posedge clk);
        bus_rst <= 1'b0;
        chk({16'h0, ens}, 32'h0);
        wreg(OFF_INDEX, 16'h0005);
        rchk(OFF_PKT_SIZE, 16'h0000);
        rchk(OFF_KIND_CTL, 16'h0000);
        rchk(OFF_BUF_LEN, 16'h0000);
        wreg(OFF_KIND_CTL, 16'h0008);
        wreg(OFF_CONTROL, 16'h0001);
        rchk(OFF_KIND_CTL, 16'h0000);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        sc_reset();
        sc_size();
        sc_kinds();
        sc_zlp();
        sc_toggle();
        sc_bus_reset();
        results();
    end
endmodule
`default_nettype wire
